// file: hdl/spc_checker.sv
// control page create checker with an AXI4-Lite register slave
// assumes the request fields are loaded by software before go
//
// Notes on behaviour
// - leaf 00H selects the create operation
// - size power of two, at least 8192
// - base aligned to region size
// - descriptor pointer 32-byte aligned
// - destination 4K aligned and inside cache
// - source 4K, security info 64-byte aligned
// - descriptor unused fields must be zero
// - security info type and reserved checked
// - slot in use or valid faults
// - guest with extensions exits on conflict
// - copy whole page before content checks
// - state mask low bits both set
// - control-flow field settings checked
// - misc select against supported mask
// - save frame pages cover state size
// - base canonical or narrow per mode
// - size below two power capability
// - attributes within mask, reserved zero
// - config fields need key separation
// - measurement block built and hashed once
// - identifier fetch-add, child count cleared
// - map entry written valid, flags clear
`include "spc_defines.svh"
module spc_checker
  import spc_pkg::*;
(
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // write address
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [7:0]  s_axi_awaddr,
  // write data
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  // write response
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  // read address
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [7:0]  s_axi_araddr,
  // read data
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  // hash engine
  output logic             hash_start,
  output logic [511:0]     hash_block
);

  // ****************************************
  // registers
  // ****************************************
  logic [31:0] ctrl, desc, dest, srcpg, security_info_block, size, base, attr, ssa, misc;
  logic [31:0] cfa, lbo, caps, xsize, flags, instance_id, nextid, map_entry;
  logic [31:0] status;
  spc_state_type  state;
  spc_result_type result;
  logic [3:0]  copy_cnt;
  logic        aw_held, w_held;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        go;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        old[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return old;
  endfunction

  // ****************************************
  // write channel
  // ****************************************
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  wire   wr_fire       = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 8'h00;
      w_data  <= 32'h00000000;
      w_strb  <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_held <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'h0;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (aw_addr > `SPC_REG_NEXTID || aw_addr[1:0] != 2'h0) ? 2'h2 : 2'h0;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // inputs are frozen while a run is busy so checks see one consistent snapshot
  wire busy = (state != SPC_IDLE);
  wire wr_ok = wr_fire && !busy;
  assign go = wr_ok && aw_addr == `SPC_REG_CTRL && w_strb[0] && w_data[`SPC_CTRL_GO];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= 32'h00000000; desc <= 32'h00000000; dest <= 32'h00000000;
      srcpg <= 32'h00000000; security_info_block <= 32'h00000000; size <= 32'h00000000;
      base <= 32'h00000000; attr <= 32'h00000000; ssa <= 32'h00000000;
      misc <= 32'h00000000; cfa <= 32'h00000000; lbo <= 32'h00000000;
      caps <= 32'h00000000; xsize <= 32'h00000000; flags <= 32'h00000000;
    end else if (wr_ok) begin
      case (aw_addr)
        `SPC_REG_CTRL:    ctrl    <= merge(ctrl, w_data, w_strb);
        `SPC_REG_DESC:    desc    <= merge(desc, w_data, w_strb);
        `SPC_REG_DEST:    dest    <= merge(dest, w_data, w_strb);
        `SPC_REG_SRCPG:   srcpg   <= merge(srcpg, w_data, w_strb);
        `SPC_REG_SECURITY_INFO_BLOCK: security_info_block <= merge(security_info_block, w_data, w_strb);
        `SPC_REG_SIZE:    size    <= merge(size, w_data, w_strb);
        `SPC_REG_BASE:    base    <= merge(base, w_data, w_strb);
        `SPC_REG_ATTR:    attr    <= merge(attr, w_data, w_strb);
        `SPC_REG_SSA:     ssa     <= merge(ssa, w_data, w_strb);
        `SPC_REG_MISC:    misc    <= merge(misc, w_data, w_strb);
        `SPC_REG_CFA:     cfa     <= merge(cfa, w_data, w_strb);
        `SPC_REG_LBO:     lbo     <= merge(lbo, w_data, w_strb);
        `SPC_REG_CAPS:    caps    <= merge(caps, w_data, w_strb);
        `SPC_REG_XSIZE:   xsize   <= merge(xsize, w_data, w_strb);
        `SPC_REG_FLAGS:   flags   <= merge(flags, w_data, w_strb);
        default: ;
      endcase
    end
  end

  // ****************************************
  // checks
  // ****************************************
  // ctrl[15:8] leaf, caps[7:0] narrow log2 limit, caps[15:8] wide, caps[31:16] attr mask
  // misc register: [15:0] select, [31:16] supported options
  logic [63:0] size64, base64, sum64, lim;
  logic [7:0]  lg;
  always_comb begin
    size64 = {32'h00000000, size};
    base64 = {32'h00000000, base};
    sum64  = base64 + {32'h00000000, lbo};
    lg     = flags[`SPC_F_WIDE] ? caps[15:8] : caps[7:0];
    lim    = (lg >= 8'd64) ? 64'hFFFFFFFFFFFFFFFF : (64'h1 << lg);
  end

  // pre-copy checks, in order
  spc_result_type pre_res;
  always_comb begin
    pre_res = SPC_OK;
    if (desc[4:0] != 5'h00) pre_res = SPC_GP;
    else if (dest[11:0] != 12'h000) pre_res = SPC_GP;
    else if (!flags[`SPC_F_IN_CACHE]) pre_res = SPC_PF;
    else if (srcpg[11:0] != 12'h000 || security_info_block[5:0] != 6'h00) pre_res = SPC_GP;
    else if (flags[`SPC_F_DESC_LIN] || flags[`SPC_F_DESC_CP]) pre_res = SPC_GP;
    else if (flags[`SPC_F_SI_RSVD] || !flags[`SPC_F_SI_TYPE]) pre_res = SPC_GP;
    else if (flags[`SPC_F_IN_USE])
      pre_res = (flags[`SPC_F_NONROOT] && flags[`SPC_F_VIRT_EXT]) ? SPC_EXIT : SPC_GP;
    else if (flags[`SPC_F_MAP_VALID]) pre_res = SPC_PF;
  end

  // content checks after the copy
  spc_result_type post_res;
  always_comb begin
    post_res = SPC_OK;
    if ((attr & 32'h00000003) != 32'h00000003) post_res = SPC_GP;
    else if (flags[`SPC_F_EXTENDED_STATE_MASK_ILL]) post_res = SPC_GP;
    else if ((!flags[`SPC_F_CF_EN] && (cfa != 0 || lbo != 0))
          || (!flags[`SPC_F_IBT] && (lbo != 0 || cfa[5:2] != 4'h0))
          || (!flags[`SPC_F_SS] && cfa[1:0] != 2'h0)
          || flags[`SPC_F_CF_RSVD] || lbo[11:0] != 12'h000
          || flags[`SPC_F_LBO_BAD] || (!flags[`SPC_F_WIDE] && sum64[63:32] != 32'h0))
      post_res = SPC_GP;
    else if ((misc[31:16] & misc[15:0]) == 16'h0000) post_res = SPC_GP;
    else if ({ssa, 12'h000} < {12'h000, xsize}) post_res = SPC_GP;
    // base is held in 32 bits, so the narrow test cannot trip here;
    // wide mode leans on the noncanonical flag from the address unit
    else if (flags[`SPC_F_WIDE] ? flags[`SPC_F_LBO_BAD] : base64[63:32] != 32'h0)
      post_res = SPC_GP;
    else if (size64 >= lim) post_res = SPC_GP;
    else if (size64 < `SPC_MIN_SIZE || $countones(size) != 1) post_res = SPC_GP;
    else if ((base & (size - 32'h1)) != 32'h0) post_res = SPC_GP;
    else if ((attr[31:16] & ~caps[31:16]) != 16'h0 || flags[`SPC_F_RSVD]) post_res = SPC_GP;
    else if (flags[`SPC_F_CFG_NZ] && !flags[`SPC_F_KSS]) post_res = SPC_GP;
  end

  // ****************************************
  // sequencer
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state    <= SPC_IDLE;
      result   <= SPC_OK;
      copy_cnt <= 4'h0;
    end else begin
      case (state)
        SPC_IDLE: if (go) begin
          if (w_data[15:8] != `SPC_LEAF_CREATE) begin
            result <= SPC_GP;
            state  <= SPC_DONE;
          end else if (pre_res != SPC_OK) begin
            result <= pre_res;
            state  <= SPC_DONE;
          end else begin
            copy_cnt <= 4'hF;
            state    <= SPC_COPY;
          end
        end
        // page move modelled as sixteen beats of 256 bytes
        SPC_COPY: begin
          copy_cnt <= copy_cnt - 4'h1;
          if (copy_cnt == 4'h0) state <= SPC_CHECK;
        end
        SPC_CHECK: begin
          result <= post_res;
          state  <= SPC_DONE;
        end
        SPC_DONE: state <= SPC_IDLE;
        default: state <= SPC_IDLE;
      endcase
    end
  end

  wire commit = (state == SPC_CHECK) && post_res == SPC_OK;

  // ****************************************
  // commit
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hash_start <= 1'b0;
      hash_block <= '0;
      instance_id        <= 32'h00000000;
      nextid     <= 32'h00000000;
      map_entry  <= 32'h00000000;
    end else begin
      hash_start <= commit;
      if (commit) begin
        hash_block          <= '0;
        hash_block[63:0]    <= `SPC_HASH_TAG;
        hash_block[95:64]   <= ssa;
        hash_block[159:96]  <= size64;
        hash_block[223:160] <= flags[`SPC_F_IBT] ? {32'h0, lbo} : 64'h0;
        instance_id       <= nextid;
        nextid    <= nextid + 32'h1;
        map_entry <= {23'h0, 1'b1, `SPC_PT_CONTROL};
      end
    end
  end

  // bit0 busy, [2:1] result, bit3 idle, [7:4] reads 1 once any commit has happened, [15:8] child count = 0
  logic [3:0] upd_cnt;
  always_ff @(posedge aclk) begin
    if (!aresetn) upd_cnt <= 4'h0;
    else if (commit) upd_cnt <= 4'h1;
  end
  assign status = {16'h0, 8'h00, upd_cnt, (state == SPC_IDLE), result, busy};

  // ****************************************
  // read channel
  // ****************************************
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= 2'h0;
      case (s_axi_araddr)
        `SPC_REG_CTRL:    s_axi_rdata <= ctrl;
        `SPC_REG_STATUS:  s_axi_rdata <= status;
        `SPC_REG_DESC:    s_axi_rdata <= desc;
        `SPC_REG_DEST:    s_axi_rdata <= dest;
        `SPC_REG_SRCPG:   s_axi_rdata <= srcpg;
        `SPC_REG_SECURITY_INFO_BLOCK: s_axi_rdata <= security_info_block;
        `SPC_REG_SIZE:    s_axi_rdata <= size;
        `SPC_REG_BASE:    s_axi_rdata <= base;
        `SPC_REG_ATTR:    s_axi_rdata <= attr;
        `SPC_REG_SSA:     s_axi_rdata <= ssa;
        `SPC_REG_MISC:    s_axi_rdata <= misc;
        `SPC_REG_CFA:     s_axi_rdata <= cfa;
        `SPC_REG_LBO:     s_axi_rdata <= lbo;
        `SPC_REG_CAPS:    s_axi_rdata <= caps;
        `SPC_REG_XSIZE:   s_axi_rdata <= xsize;
        `SPC_REG_FLAGS:   s_axi_rdata <= flags;
        `SPC_REG_EID:     s_axi_rdata <= instance_id;
        `SPC_REG_MAP:     s_axi_rdata <= map_entry;
        `SPC_REG_NEXTID:  s_axi_rdata <= nextid;
        default: begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= 2'h2;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ****************************************
  // checks on behaviour
  // ****************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_copy_run;
    state == SPC_COPY [*8] ##1 state == SPC_COPY [*8];
  endsequence

  chk_copy_length: assert property (state == SPC_IDLE ##1 state == SPC_COPY |-> s_copy_run ##1 state == SPC_CHECK) else $error("copy not sixteen beats");
  chk_leaf_select: assert property (go && w_data[15:8] != `SPC_LEAF_CREATE |=> state == SPC_DONE && result == SPC_GP) else $error("bad leaf accepted");
  chk_desc_align: assert property (go && w_data[15:8] == 8'h00 && desc[4:0] != 5'h0 |=> result == SPC_GP) else $error("unaligned descriptor");
  chk_conflict_exit: assert property (go && w_data[15:8] == 8'h00 && pre_res == SPC_EXIT |=> result == SPC_EXIT) else $error("exit missing");
  chk_min_size: assert property (state == SPC_CHECK && size < 32'h2000 |=> result != SPC_OK) else $error("small size ok");
  chk_hash_once: assert property (hash_start |=> !hash_start) else $error("hash twice");
  chk_hash_tag: assert property (hash_start |-> hash_block[63:0] == `SPC_HASH_TAG) else $error("bad tag");
  chk_id_step: assert property (commit |=> nextid == $past(nextid) + 32'h1 && instance_id == $past(nextid)) else $error("id step");
  chk_map_valid: assert property (commit |=> map_entry[8] && map_entry[7:0] == `SPC_PT_CONTROL) else $error("map entry");
  chk_no_commit: assert property (state == SPC_CHECK && post_res != SPC_OK |=> $stable(nextid) && !hash_start) else $error("committed on fail");

  // ****************************************
  // checks on the commit path
  // ****************************************
  // registers are frozen while busy, so copy beats still see the go-time snapshot
  sequence s_commit_step;
    state == SPC_CHECK ##1 state == SPC_DONE && hash_start;
  endsequence

  chk_commit_pulse: assert property (commit |-> s_commit_step)
    else $error("commit not followed by hash pulse");
  chk_hash_pad: assert property (hash_start |-> hash_block[511:224] == '0)
    else $error("hash block padding not zero");
  chk_hash_ibt: assert property (
    hash_start && !flags[`SPC_F_IBT] |-> hash_block[223:160] == 64'h0)
    else $error("legacy offset hashed without ibt");
  chk_copy_entry: assert property (
    state == SPC_COPY |-> srcpg[11:0] == 12'h000 && security_info_block[5:0] == 6'h00)
    else $error("copy started with unaligned source");
  chk_copy_slot: assert property (
    state == SPC_COPY |-> !flags[`SPC_F_IN_USE] && !flags[`SPC_F_MAP_VALID])
    else $error("copy started into a busy slot");
  chk_save_frame: assert property (commit |-> {ssa, 12'h000} >= {12'h000, xsize})
    else $error("save frame too small on commit");
  chk_cfg_share: assert property (commit |-> !flags[`SPC_F_CFG_NZ] || flags[`SPC_F_KSS])
    else $error("config fields without key sharing");
  chk_map_hold: assert property (!commit |=> $stable(map_entry) && $stable(instance_id))
    else $error("map entry changed without commit");

endmodule // spc_checker

// file: hdl/spc_defines.svh
// constants for the control page create checker
// assumes a 100 MHz aclk and a single AXI4-Lite register slave
`ifndef SPC_DEFINES_SVH
`define SPC_DEFINES_SVH
`define SPC_LEAF_CREATE     8'h00
`define SPC_MIN_SIZE        64'h0000000000002000
`define SPC_EXTENDED_STATE_MASK_LOW        64'h0000000000000003
`define SPC_PAGE_BYTES      32'h00001000
`define SPC_HASH_TAG        64'h0045544145524345
`define SPC_PT_CONTROL      8'h01
// register byte addresses
`define SPC_REG_CTRL        8'h00
`define SPC_REG_STATUS      8'h04
`define SPC_REG_DESC        8'h08
`define SPC_REG_DEST        8'h0C
`define SPC_REG_SRCPG       8'h10
`define SPC_REG_SECURITY_INFO_BLOCK     8'h14
`define SPC_REG_SIZE        8'h18
`define SPC_REG_BASE        8'h1C
`define SPC_REG_ATTR        8'h20
`define SPC_REG_SSA         8'h24
`define SPC_REG_MISC        8'h28
`define SPC_REG_CFA         8'h2C
`define SPC_REG_LBO         8'h30
`define SPC_REG_CAPS        8'h34
`define SPC_REG_XSIZE       8'h38
`define SPC_REG_FLAGS       8'h3C
`define SPC_REG_EID         8'h40
`define SPC_REG_MAP         8'h44
`define SPC_REG_NEXTID      8'h48
// control bits
`define SPC_CTRL_GO         0
// flags register fields
`define SPC_F_DESC_LIN      0
`define SPC_F_DESC_CP       1
`define SPC_F_SI_TYPE       2
`define SPC_F_SI_RSVD       3
`define SPC_F_IN_CACHE      4
`define SPC_F_IN_USE        5
`define SPC_F_MAP_VALID     6
`define SPC_F_NONROOT       7
`define SPC_F_VIRT_EXT      8
`define SPC_F_EXTENDED_STATE_MASK_ILL      9
`define SPC_F_CF_EN         10
`define SPC_F_IBT           11
`define SPC_F_SS            12
`define SPC_F_CF_RSVD       13
`define SPC_F_WIDE          14
`define SPC_F_KSS           15
`define SPC_F_RSVD          16
`define SPC_F_CFG_NZ        17
`define SPC_F_LBO_BAD       18
`endif

// file: hdl/spc_pkg.sv
// types shared by the control page create checker
// assumes the defines header is included by the users
package spc_pkg;
  typedef enum logic [1:0] {
    SPC_OK,
    SPC_GP,
    SPC_PF,
    SPC_EXIT
  } spc_result_type;
  typedef enum {
    SPC_IDLE,
    SPC_COPY,
    SPC_CHECK,
    SPC_DONE
  } spc_state_type;
endpackage

// file: tb/spc_checker_tb.sv
// self-checking bench for the control page create checker
// assumes the checker's AXI4-Lite slave, defines header and package as shipped
`include "spc_defines.svh"
module spc_checker_tb
  import spc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic         aclk, aresetn;
  logic         s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic [7:0]   s_axi_awaddr, s_axi_araddr;
  logic [31:0]  s_axi_wdata, s_axi_rdata;
  logic [3:0]   s_axi_wstrb;
  logic         s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic         s_axi_rvalid, s_axi_rready, hash_start;
  logic [1:0]   s_axi_bresp, s_axi_rresp;
  logic [511:0] hash_block, hb_exp;
  logic [31:0]  good [14];
  logic [31:0]  rd, id0;
  logic [1:0]   rsp;
  int           n_errors, n_tests, n_hash, h0;

  spc_checker dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .hash_start(hash_start), .hash_block(hash_block));

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  always @(posedge aclk) begin
    if (hash_start === 1'b1) n_hash++;
  end

  // ****************************************
  // bus tasks and comparison
  // ****************************************
  task automatic chk(input logic [511:0] seen, input logic [511:0] exp, input string what);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t %s seen %0h expected %0h", $time, what, seen, exp);
    end
  endtask

  // handshakes observed mid-cycle, where they stand settled until the next rising edge
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw, w, b;
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr  <= a;
    s_axi_wvalid  <= 1'b1;
    s_axi_wdata   <= d;
    b = 1'b0;
    while (!b) begin
      @(negedge aclk);
      aw = s_axi_awvalid & s_axi_awready;
      w  = s_axi_wvalid & s_axi_wready;
      b  = s_axi_bvalid & s_axi_bready;
      r  = s_axi_bresp;
      @(posedge aclk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar, rv;
    s_axi_arvalid <= 1'b1;
    s_axi_araddr  <= a;
    rv = 1'b0;
    while (!rv) begin
      @(negedge aclk);
      ar = s_axi_arvalid & s_axi_arready;
      rv = s_axi_rvalid & s_axi_rready;
      d  = s_axi_rdata;
      r  = s_axi_rresp;
      @(posedge aclk);
      if (ar) s_axi_arvalid <= 1'b0;
    end
  endtask

  task automatic load_good();
    for (int i = 0; i < 14; i++) axi_wr(8'(8 + 4 * i), good[i], rsp);
  endtask

  task automatic go_wait(input logic [31:0] c);
    axi_wr(`SPC_REG_CTRL, c, rsp);
    rd = 32'h00000001;
    while (rd[0] !== 1'b0) axi_rd(`SPC_REG_STATUS, rd, rsp);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic run_fault(input logic [7:0] a, input logic [31:0] v, input logic [1:0] exp);
    load_good();
    axi_wr(a, v, rsp);
    go_wait(32'h00000001);
    chk(rd[2:1], exp, "fault result");
    axi_rd(`SPC_REG_MAP, rd, rsp);
    chk(rd[8], exp == SPC_OK, "map valid only on success");
  endtask

  task automatic run_leaf(input logic [7:0] leaf);
    load_good();
    go_wait({16'h0000, leaf, 8'h01});
    chk(rd[2:1], SPC_GP, "leaf refused");
    axi_rd(`SPC_REG_MAP, rd, rsp);
    chk(rd[8], 1'b0, "map left invalid after leaf");
  endtask

  task automatic run_good(input logic [31:0] ssa, input logic [31:0] lbo, input logic [31:0] fl);
    load_good();
    axi_wr(`SPC_REG_SSA, ssa, rsp);
    axi_wr(`SPC_REG_LBO, lbo, rsp);
    axi_wr(`SPC_REG_FLAGS, fl, rsp);
    axi_rd(`SPC_REG_NEXTID, id0, rsp);
    h0 = n_hash;
    axi_wr(`SPC_REG_CTRL, 32'h00000001, rsp);
    // write while busy is acknowledged but must not disturb the request
    axi_wr(`SPC_REG_SIZE, 32'h00001000, rsp);
    chk(rsp, 2'b00, "busy write response");
    rd = 32'h00000001;
    while (rd[0] !== 1'b0) axi_rd(`SPC_REG_STATUS, rd, rsp);
    chk(rd[7:0], 8'h18, "status after create");
    chk(n_hash - h0, 1, "one hash pulse");
    hb_exp = '0;
    hb_exp[63:0]    = `SPC_HASH_TAG;
    hb_exp[95:64]   = ssa;
    hb_exp[159:96]  = {32'h00000000, good[4]};
    hb_exp[223:160] = fl[`SPC_F_IBT] ? {32'h00000000, lbo} : 64'h0;
    chk(hash_block, hb_exp, "measurement block");
    axi_rd(`SPC_REG_EID, rd, rsp);
    chk(rd, id0, "instance id");
    axi_rd(`SPC_REG_NEXTID, rd, rsp);
    chk(rd, id0 + 32'h00000001, "next id");
    axi_rd(`SPC_REG_MAP, rd, rsp);
    chk(rd, 32'h00000101, "map entry");
    axi_rd(`SPC_REG_SIZE, rd, rsp);
    chk(rd, good[4], "size kept while busy");
  endtask

  task automatic end_sim();
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge aclk);
    n_errors++;
    $display("[FAIL] %0t run did not finish", $time);
    end_sim();
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
    // always ready for answers: a single transfer at most is ever outstanding
    {s_axi_bready, s_axi_rready} = 2'b11;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata  = 32'h00000000;
    s_axi_wstrb  = 4'hF;
    aresetn      = 1'b0;
    good = '{32'h00000040, 32'h00003000, 32'h00005000, 32'h00000080, 32'h00002000,
             32'h00004000, 32'h00010003, 32'h00000001, 32'h00010001, 32'h00000000,
             32'h00000000, 32'hFFFF2014, 32'h00000100, 32'h00000014};
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    axi_rd(`SPC_REG_STATUS, rd, rsp);
    chk(rd, 32'h00000008, "status after reset");
    axi_rd(8'h4C, rd, rsp);
    chk({rsp, rd}, {2'b10, 32'h00000000}, "unmapped read");
    axi_wr(8'h50, 32'h00000001, rsp);
    chk(rsp, 2'b10, "unmapped write");
    axi_rd(`SPC_REG_NEXTID, id0, rsp);
    run_leaf(8'h01);
    run_fault(`SPC_REG_SIZE, 32'h00001000, SPC_GP);
    run_fault(`SPC_REG_SIZE, 32'h00003000, SPC_GP);
    run_fault(`SPC_REG_BASE, 32'h00005000, SPC_GP);
    run_fault(`SPC_REG_DESC, 32'h00000044, SPC_GP);
    run_fault(`SPC_REG_DEST, 32'h00003100, SPC_GP);
    run_fault(`SPC_REG_FLAGS, 32'h00000004, SPC_PF);
    run_fault(`SPC_REG_SRCPG, 32'h00005040, SPC_GP);
    run_fault(`SPC_REG_SECURITY_INFO_BLOCK, 32'h00000084, SPC_GP);
    run_fault(`SPC_REG_FLAGS, 32'h00000015, SPC_GP);
    run_fault(`SPC_REG_FLAGS, 32'h00000016, SPC_GP);
    run_fault(`SPC_REG_FLAGS, 32'h00000010, SPC_GP);
    run_fault(`SPC_REG_FLAGS, 32'h0000001C, SPC_GP);
    run_fault(`SPC_REG_FLAGS, 32'h00000034, SPC_GP);
    run_fault(`SPC_REG_FLAGS, 32'h00000054, SPC_PF);
    run_fault(`SPC_REG_FLAGS, 32'h000001B4, SPC_EXIT);
    run_fault(`SPC_REG_FLAGS, 32'h000000B4, SPC_GP);
    run_fault(`SPC_REG_ATTR, 32'h00010001, SPC_GP);
    run_fault(`SPC_REG_FLAGS, 32'h00000214, SPC_GP);
    run_fault(`SPC_REG_CFA, 32'h00000001, SPC_GP);
    run_fault(`SPC_REG_FLAGS, 32'h00002014, SPC_GP);
    run_fault(`SPC_REG_MISC, 32'h00010002, SPC_GP);
    run_fault(`SPC_REG_XSIZE, 32'h00001001, SPC_GP);
    run_fault(`SPC_REG_FLAGS, 32'h00044014, SPC_GP);
    run_fault(`SPC_REG_CAPS, 32'hFFFF200D, SPC_GP);
    run_fault(`SPC_REG_CAPS, 32'h00002014, SPC_GP);
    run_fault(`SPC_REG_FLAGS, 32'h00010014, SPC_GP);
    run_fault(`SPC_REG_FLAGS, 32'h00020014, SPC_GP);
    // clean create last: it leaves the slot's map entry valid
    run_fault(`SPC_REG_FLAGS, 32'h00004014, SPC_OK);
    axi_rd(`SPC_REG_NEXTID, rd, rsp);
    chk(rd, id0 + 32'h00000001, "id advanced by the one clean create only");
    run_good(32'h00000001, 32'h00000000, 32'h00000014);
    run_good(32'h00000002, 32'h00001000, 32'h00028C14);
    end_sim();
  end
endmodule // spc_checker_tb
